// ---- hw/fskrx_top.sv ----
`timescale 1ns/1ps
`include "fskrx_defines.svh"

module fskrx_top (
	input wire logic clk,
	input wire logic sys_rst,
	input wire fskrx_pkg::fskrx_bus_req_t bus_req,
	output logic [7:0] rd_data,
	input wire logic demod_raw_pin,
	input wire logic [1:0] mode_switch_pins,
	input wire logic [1:0] level_cmp_pins,
	input wire fskrx_pkg::fskrx_fifo_evt_t fifo_evt,
	output logic irq_line_a,
	output logic irq_line_b,
	output logic synced_bit_out,
	output logic data_oe,
	output logic rx_active,
	output logic front_end_mode_out
);
	import fskrx_pkg::*;

	// ****************************************
	// rate constants
	// ****************************************
	localparam longint unsigned SMP_HZ = 64'(`FSKRX_BASE_RATE_HZ) * 64'(`FSKRX_OSR_DEFAULT);
	localparam longint unsigned FIX_HZ = 64'(`FSKRX_FIXED_RATE_HZ) * 64'(`FSKRX_OSR_DEFAULT);
	localparam logic [23:0] INC_BASE = 24'((SMP_HZ << `FSKRX_NCO_W) / 64'(`FSKRX_CLK_HZ));
	localparam logic [23:0] INC_FIX = 24'((FIX_HZ << `FSKRX_NCO_W) / 64'(`FSKRX_CLK_HZ));
	localparam logic [11:0] LVL_CYCLES =
		12'(64'(`FSKRX_LVL_PERIOD_US) * 64'(`FSKRX_CLK_HZ) / 64'd1000000);

	fskrx_state_t st_reg;
	fskrx_state_t st_next;
	logic match_flag;

	function automatic fskrx_state_t rst_val();
		fskrx_state_t r;
		r = '0;
		r.sync = SYNC_SEARCH;
		r.cfg.oversample_ratio_field = `FSKRX_OSR_RST;
		return r;
	endfunction

	function automatic logic majority(input logic [2:0] v);
		return (v[0] & v[1]) | (v[1] & v[2]) | (v[0] & v[2]);
	endfunction

	// ****************************************
	// reference word matcher
	// ****************************************
	fskrx_matcher u_matcher (
		.clk(clk),
		.sys_rst(sys_rst),
		.enable(st_reg.rx_active && !st_reg.cfg.synchronizer_bypass
			&& st_reg.cfg.match_enable),
		.bit_pulse(st_reg.bit_pulse),
		.bit_val(st_reg.data_bit),
		.rise_pulse(st_reg.rise_pulse),
		.pattern(st_reg.cfg.pattern),
		.len_sel(st_reg.cfg.match_length_sel),
		.tol(st_reg.cfg.match_error_tolerance),
		.match(match_flag)
	);

	// ****************************************
	// next state
	// ****************************************
	always_comb begin
		logic [24:0] sum;
		logic smp_tick;
		logic [7:0] osr_eff;
		logic [7:0] half;
		logic newbit;
		logic rx;
		logic lvl_evt;
		logic [7:0] rd;
		st_next = st_reg;
		sum = 25'h0;
		smp_tick = 1'b0;
		osr_eff = `FSKRX_OSR_RST;
		half = 8'h00;
		newbit = 1'b0;
		rx = 1'b0;
		lvl_evt = 1'b0;
		rd = 8'h00;

		// pin synchronisers
		st_next.sw_s1 = mode_switch_pins;
		st_next.sw_s2 = st_reg.sw_s1;
		st_next.raw_s1 = demod_raw_pin;
		st_next.raw_s2 = st_reg.raw_s1;
		st_next.lvl_s1 = level_cmp_pins;
		st_next.lvl_s2 = st_reg.lvl_s1;
		st_next.bit_pulse = 1'b0;
		st_next.rise_pulse = 1'b0;

		rx = st_reg.cfg.pin_mode_select ? (st_reg.sw_s2 == `FSKRX_RX_CODE)
			: (st_reg.cfg.chip_operating_field == `FSKRX_RX_CODE);

		// sample tick: base rate times 32 over divisor plus one, or fixed rate times 32 with the fixed profile bit set
		if (st_reg.cfg.fixed_rate_profile_bit) begin
			sum = {1'b0, st_reg.nco} + {1'b0, INC_FIX};
			smp_tick = sum[24];
		end else begin
			sum = {1'b0, st_reg.nco} + {1'b0, INC_BASE};
			if (sum[24]) begin
				if (st_reg.div == st_reg.cfg.rate_divisor_field) begin
					st_next.div = 7'h00;
					smp_tick = 1'b1;
				end else begin
					st_next.div = st_reg.div + 7'h01;
				end
			end
		end
		st_next.nco = sum[23:0];

		// ratio plus one samples per bit keeps the sample rate fixed
		if (st_reg.cfg.oversample_override && !st_reg.cfg.fixed_rate_profile_bit) begin
			osr_eff = st_reg.cfg.oversample_ratio_field;
		end
		half = {1'b0, osr_eff[7:1]};

		// ****************************************
		// bit synchroniser
		// ****************************************
		if (!rx || st_reg.cfg.synchronizer_bypass) begin
			st_next.sync = SYNC_SEARCH;
			st_next.bit_clk = 1'b0;
			st_next.phase = 8'h00;
		end else if (smp_tick) begin
			st_next.filt = {st_reg.filt[1:0], st_reg.raw_s2};
			newbit = majority(st_next.filt);
			st_next.bit_f = newbit;
			unique case (st_reg.sync)
				SYNC_SEARCH: begin
					if (newbit != st_reg.bit_f) begin
						st_next.phase = 8'h00;
						st_next.sync = SYNC_TRACK;
					end
				end
				SYNC_TRACK: begin
					// each transition realigns the phase; no transition keeps freewheeling
					if (newbit != st_reg.bit_f) begin
						st_next.phase = 8'h00;
					end else if (st_reg.phase >= osr_eff) begin
						st_next.phase = 8'h00;
					end else begin
						st_next.phase = st_reg.phase + 8'h01;
					end
					if (st_next.phase == half) begin
						st_next.data_bit = newbit;
						st_next.bit_pulse = 1'b1;
					end
					if (st_next.phase == half + 8'h01) begin
						st_next.bit_clk = 1'b1;
						st_next.rise_pulse = 1'b1;
					end
					if (st_next.phase == 8'h00) begin
						st_next.bit_clk = 1'b0;
					end
				end
			endcase
		end

		// ****************************************
		// level meter
		// ****************************************
		if (st_reg.cfg.level_meter_enable) begin
			if (st_reg.lvl_cnt >= LVL_CYCLES - 12'h001) begin
				st_next.lvl_cnt = 12'h000;
				st_next.level_int = st_reg.lvl_s2;
			end else begin
				st_next.lvl_cnt = st_reg.lvl_cnt + 12'h001;
			end
		end else begin
			st_next.lvl_cnt = 12'h000;
		end

		// ****************************************
		// register bus
		// ****************************************
		if (bus_req.we) begin
			unique case (bus_req.addr)
				`FSKRX_OFS_MODE: begin
					st_next.cfg.chip_operating_field = bus_req.wdata[1:0];
					st_next.cfg.pin_mode_select = bus_req.wdata[`FSKRX_MODE_PINSEL];
					st_next.cfg.fifo_path_enable = bus_req.wdata[`FSKRX_MODE_FIFO];
					st_next.cfg.fixed_rate_profile_bit = bus_req.wdata[`FSKRX_MODE_FIXED];
				end
				`FSKRX_OFS_RATE: st_next.cfg.rate_divisor_field = bus_req.wdata[6:0];
				`FSKRX_OFS_RXCFG: begin
					st_next.cfg.front_end_mode_reg = bus_req.wdata[0];
					st_next.cfg.synchronizer_bypass = bus_req.wdata[`FSKRX_RXCFG_BYPASS];
					st_next.cfg.match_enable = bus_req.wdata[`FSKRX_RXCFG_MATCH];
					st_next.cfg.match_length_sel = bus_req.wdata[4:3];
					st_next.cfg.match_error_tolerance = bus_req.wdata[6:5];
					st_next.cfg.level_meter_enable = bus_req.wdata[`FSKRX_RXCFG_LVL];
				end
				`FSKRX_OFS_OSR: st_next.cfg.oversample_ratio_field = bus_req.wdata;
				`FSKRX_OFS_OSRCTL: st_next.cfg.oversample_override = bus_req.wdata[0];
				`FSKRX_OFS_IRQ: begin
					st_next.cfg.line_a_source_sel = bus_req.wdata[1:0];
					st_next.cfg.line_b_source_sel = bus_req.wdata[3:2];
					st_next.cfg.level_irq_enable = bus_req.wdata[`FSKRX_IRQ_LVLEN];
					st_next.cfg.level_irq_threshold = bus_req.wdata[6:5];
					if (bus_req.wdata[`FSKRX_IRQ_DETECT]) begin
						st_next.level_detect_flag = 1'b0;
					end
				end
				default: begin
					for (int i = 0; i < 4; i++) begin
						if (bus_req.addr == `FSKRX_OFS_PAT0 + 8'(i)) begin
							st_next.cfg.pattern[i*8 +: 8] = bus_req.wdata;
						end
					end
				end
			endcase
		end

		// detect set wins over a clear in the same cycle
		if (st_reg.cfg.level_irq_enable && st_reg.cfg.level_meter_enable
			&& st_reg.level_int >= st_reg.cfg.level_irq_threshold) begin
			st_next.level_detect_flag = 1'b1;
		end
		lvl_evt = st_reg.level_detect_flag;

		if (bus_req.re) begin
			unique case (bus_req.addr)
				`FSKRX_OFS_MODE: rd = {3'h0, st_reg.cfg.fixed_rate_profile_bit,
					st_reg.cfg.fifo_path_enable, st_reg.cfg.pin_mode_select,
					st_reg.cfg.chip_operating_field};
				`FSKRX_OFS_RATE: rd = {1'b0, st_reg.cfg.rate_divisor_field};
				`FSKRX_OFS_RXCFG: rd = {st_reg.cfg.level_meter_enable,
					st_reg.cfg.match_error_tolerance, st_reg.cfg.match_length_sel,
					st_reg.cfg.match_enable, st_reg.cfg.synchronizer_bypass,
					st_reg.cfg.front_end_mode_reg};
				`FSKRX_OFS_OSR: rd = st_reg.cfg.oversample_ratio_field;
				`FSKRX_OFS_OSRCTL: rd = {7'h00, st_reg.cfg.oversample_override};
				`FSKRX_OFS_IRQ: rd = {st_reg.level_detect_flag, st_reg.cfg.level_irq_threshold,
					st_reg.cfg.level_irq_enable, st_reg.cfg.line_b_source_sel,
					st_reg.cfg.line_a_source_sel};
				`FSKRX_OFS_LEVEL: begin
					st_next.level_class_out = st_reg.level_int;
					rd = {5'h00, st_reg.rx_active, st_next.level_class_out};
				end
				default: begin
					for (int i = 0; i < 4; i++) begin
						if (bus_req.addr == `FSKRX_OFS_PAT0 + 8'(i)) begin
							rd = st_reg.cfg.pattern[i*8 +: 8];
						end
					end
				end
			endcase
		end
		st_next.rd_data = rd;

		// ****************************************
		// pin routing
		// ****************************************
		st_next.rx_active = rx;
		st_next.front_end_out = st_reg.cfg.front_end_mode_reg;
		st_next.irq_a = 1'b0;
		st_next.irq_b = 1'b0;
		st_next.data_out = 1'b0;
		st_next.data_oe = 1'b0;
		if (rx && !st_reg.cfg.fifo_path_enable) begin
			st_next.irq_a = (st_reg.cfg.line_a_source_sel == 2'h1) ? lvl_evt
				: match_flag;
			st_next.irq_b = st_reg.bit_clk;
			st_next.data_oe = 1'b1;
			st_next.data_out = st_reg.cfg.synchronizer_bypass ? st_reg.raw_s2
				: st_reg.data_bit;
		end else if (rx) begin
			unique case (st_reg.cfg.line_a_source_sel)
				2'h0: st_next.irq_a = 1'b0;
				2'h1: st_next.irq_a = fifo_evt.byte_written;
				2'h2: st_next.irq_a = fifo_evt.fifo_not_empty;
				2'h3: st_next.irq_a = match_flag;
			endcase
			unique case (st_reg.cfg.line_b_source_sel)
				2'h0: st_next.irq_b = 1'b0;
				2'h1: st_next.irq_b = fifo_evt.fifo_full;
				2'h2, 2'h3: st_next.irq_b = lvl_evt;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			st_reg <= rst_val();
		end else begin
			st_reg <= st_next;
		end
	end

	assign rd_data = st_reg.rd_data;
	assign irq_line_a = st_reg.irq_a;
	assign irq_line_b = st_reg.irq_b;
	assign synced_bit_out = st_reg.data_out;
	assign data_oe = st_reg.data_oe;
	assign rx_active = st_reg.rx_active;
	assign front_end_mode_out = st_reg.front_end_out;
endmodule

// ---- pkg/fskrx_defines.svh ----
`ifndef FSKRX_DEFINES_SVH
`define FSKRX_DEFINES_SVH

// ****************************************
// clock and timing
// ****************************************
`define FSKRX_CLK_HZ 10000000
`define FSKRX_BASE_RATE_HZ 152340
`define FSKRX_OSR_DEFAULT 32
`define FSKRX_FIXED_RATE_HZ 32768
`define FSKRX_LVL_PERIOD_US 100
`define FSKRX_NCO_W 24

// ****************************************
// register offsets
// ****************************************
`define FSKRX_OFS_MODE 8'h00
`define FSKRX_OFS_RATE 8'h01
`define FSKRX_OFS_RXCFG 8'h02
`define FSKRX_OFS_OSR 8'h03
`define FSKRX_OFS_OSRCTL 8'h04
`define FSKRX_OFS_IRQ 8'h05
`define FSKRX_OFS_LEVEL 8'h06
`define FSKRX_OFS_PAT0 8'h08

// ****************************************
// field positions
// ****************************************
`define FSKRX_MODE_PINSEL 2
`define FSKRX_MODE_FIFO 3
`define FSKRX_MODE_FIXED 4
`define FSKRX_RXCFG_BYPASS 1
`define FSKRX_RXCFG_MATCH 2
`define FSKRX_RXCFG_LVL 7
`define FSKRX_IRQ_LVLEN 4
`define FSKRX_IRQ_DETECT 7
`define FSKRX_LEVEL_RX 2

// ****************************************
// reset values and codes
// ****************************************
`define FSKRX_OSR_RST 8'h1F
`define FSKRX_RX_CODE 2'h1

`endif

// ---- pkg/fskrx_pkg.sv ----
package fskrx_pkg;

	// ****************************************
	// carriers
	// ****************************************
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic we;
		logic re;
	} fskrx_bus_req_t;

	typedef struct packed {
		logic byte_written;
		logic fifo_not_empty;
		logic fifo_full;
	} fskrx_fifo_evt_t;

	typedef enum logic [1:0] {
		SYNC_SEARCH = 2'b01,
		SYNC_TRACK = 2'b10
	} fskrx_sync_e_t;

	typedef struct packed {
		logic [1:0] chip_operating_field;
		logic pin_mode_select;
		logic fifo_path_enable;
		logic fixed_rate_profile_bit;
		logic [6:0] rate_divisor_field;
		logic front_end_mode_reg;
		logic synchronizer_bypass;
		logic match_enable;
		logic [1:0] match_length_sel;
		logic [1:0] match_error_tolerance;
		logic level_meter_enable;
		logic [7:0] oversample_ratio_field;
		logic oversample_override;
		logic [1:0] line_a_source_sel;
		logic [1:0] line_b_source_sel;
		logic level_irq_enable;
		logic [1:0] level_irq_threshold;
		logic [31:0] pattern;
	} fskrx_cfg_t;

	typedef struct packed {
		fskrx_cfg_t cfg;
		logic [1:0] sw_s1;
		logic [1:0] sw_s2;
		logic raw_s1;
		logic raw_s2;
		logic [1:0] lvl_s1;
		logic [1:0] lvl_s2;
		logic [2:0] filt;
		logic bit_f;
		fskrx_sync_e_t sync;
		logic [23:0] nco;
		logic [6:0] div;
		logic [7:0] phase;
		logic bit_pulse;
		logic rise_pulse;
		logic bit_clk;
		logic data_bit;
		logic [1:0] level_int;
		logic [1:0] level_class_out;
		logic level_detect_flag;
		logic [11:0] lvl_cnt;
		logic irq_a;
		logic irq_b;
		logic data_out;
		logic data_oe;
		logic rx_active;
		logic front_end_out;
		logic [7:0] rd_data;
	} fskrx_state_t;

	typedef struct packed {
		logic [31:0] shreg;
		logic match;
	} fskrx_match_state_t;

endpackage

// ---- hw/fskrx_matcher.sv ----
`timescale 1ns/1ps
`include "fskrx_defines.svh"

module fskrx_matcher (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic enable,
	input wire logic bit_pulse,
	input wire logic bit_val,
	input wire logic rise_pulse,
	input wire logic [31:0] pattern,
	input wire logic [1:0] len_sel,
	input wire logic [1:0] tol,
	output logic match
);
	import fskrx_pkg::*;

	fskrx_match_state_t st_reg;
	fskrx_match_state_t st_next;

	function automatic logic [5:0] popcount(input logic [31:0] v);
		logic [5:0] n;
		n = 6'h00;
		for (int i = 0; i < 32; i++) begin
			n = n + {5'h00, v[i]};
		end
		return n;
	endfunction

	// compared length is 8, 16, 24 or 32 bits, newest bits at the bottom
	function automatic logic [31:0] len_mask(input logic [1:0] sel);
		logic [31:0] m;
		m = 32'h0000_0000;
		for (int i = 0; i < 4; i++) begin
			if (2'(i) <= sel) begin
				m[i*8 +: 8] = 8'hFF;
			end
		end
		return m;
	endfunction

	always_comb begin
		st_next = st_reg;
		if (!enable) begin
			st_next.match = 1'b0;
		end else begin
			if (bit_pulse) begin
				st_next.shreg = {st_reg.shreg[30:0], bit_val};
			end
			if (rise_pulse) begin
				st_next.match = popcount((st_reg.shreg ^ pattern) & len_mask(len_sel))
					<= {4'h0, tol};
			end
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign match = st_reg.match;
endmodule

// ---- bench/fskrx_top_assertions.sv ----
`timescale 1ns/1ps
module fskrx_top_assertions (
	input wire logic clk,
	input wire logic sys_rst,
	input wire fskrx_pkg::fskrx_bus_req_t bus_req,
	input wire logic [7:0] rd_data,
	input wire logic demod_raw_pin,
	input wire logic [1:0] mode_switch_pins,
	input wire logic [1:0] level_cmp_pins,
	input wire fskrx_pkg::fskrx_fifo_evt_t fifo_evt,
	input wire logic irq_line_a,
	input wire logic irq_line_b,
	input wire logic synced_bit_out,
	input wire logic data_oe,
	input wire logic rx_active,
	input wire logic front_end_mode_out
);
	import fskrx_pkg::*;
	// ****
	// shadow of written mode, receive and line settings
	// ****
	logic [23:0] cfg_reg;
	logic [23:0] cfg_d_reg;
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			cfg_reg <= 24'h000000;
			cfg_d_reg <= 24'h000000;
		end else begin
			cfg_d_reg <= cfg_reg;
			if (bus_req.we && bus_req.addr == 8'h00) cfg_reg[7:0] <= bus_req.wdata;
			if (bus_req.we && bus_req.addr == 8'h02) cfg_reg[15:8] <= bus_req.wdata;
			if (bus_req.we && bus_req.addr == 8'h05) cfg_reg[23:16] <= {1'h0, bus_req.wdata[6:0]};
		end
	end
	wire st = cfg_reg == cfg_d_reg;
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);
	AST_RX_SELECT: assert property (st |-> rx_active == (cfg_reg[2] ?
		$past(mode_switch_pins, 3) == 2'h1 : cfg_reg[1:0] == 2'h1)) else $error("rx select");
	AST_FRONT_END: assert property (front_end_mode_out == cfg_d_reg[8])
		else $error("front end mode");
	AST_IDLE_LINES: assert property (!rx_active && !$past(rx_active) |->
		!irq_line_a && !irq_line_b && !data_oe) else $error("lines active outside rx");
	AST_BYPASS_CLOCK: assert property (st && $past(st) && cfg_reg[9] && !cfg_reg[3]
		|-> !irq_line_b) else $error("bit clock not low in bypass");
	AST_BYPASS_DATA: assert property (st && cfg_reg[9] && !cfg_reg[3] && rx_active
		&& $past(rx_active) |-> synced_bit_out == $past(demod_raw_pin, 3)) else $error("raw data");
	AST_MATCH_QUIET: assert property (st && $past(st) && (cfg_reg[9] || !cfg_reg[10])
		&& !cfg_reg[3] && cfg_reg[17:16] != 2'h1 |-> !irq_line_a) else $error("match flag");
	AST_MATCH_EDGE: assert property ($changed(irq_line_a) && st && $past(st) && !cfg_reg[3]
		&& cfg_reg[17:16] != 2'h1 |-> $past(irq_line_b) && !$past(irq_line_b, 2))
		else $error("match flag off clock edge");
	AST_FIFO_LINE_A: assert property (st && cfg_reg[3] && rx_active && $past(rx_active)
		&& cfg_reg[17:16] != 2'h3 |-> irq_line_a == (cfg_reg[17:16] == 2'h1 ?
		$past(fifo_evt.byte_written) : cfg_reg[17:16] == 2'h2 && $past(fifo_evt.fifo_not_empty)))
		else $error("line a source");
	AST_FIFO_LINE_B: assert property (st && cfg_reg[3] && rx_active && $past(rx_active)
		&& !cfg_reg[19] |-> irq_line_b == (cfg_reg[18] && $past(fifo_evt.fifo_full)))
		else $error("line b source");
	AST_READ_IDLE: assert property (!$past(bus_req.re) |-> rd_data == 8'h00)
		else $error("read data outside slot");
	AST_LEVEL_READ: assert property ($past(bus_req.re) && $past(bus_req.addr) == 8'h06
		|-> rd_data[7:2] == {5'h00, $past(rx_active)}) else $error("level read");
	cover property ($rose(irq_line_b));
	cover property ($rose(irq_line_a) && !cfg_reg[3]);
	cover property ($rose(rx_active) && cfg_reg[2]);
endmodule

bind fskrx_top fskrx_top_assertions u_chk (.clk(clk), .sys_rst(sys_rst), .bus_req(bus_req),
	.rd_data(rd_data), .demod_raw_pin(demod_raw_pin), .mode_switch_pins(mode_switch_pins),
	.level_cmp_pins(level_cmp_pins), .fifo_evt(fifo_evt), .irq_line_a(irq_line_a),
	.irq_line_b(irq_line_b), .synced_bit_out(synced_bit_out), .data_oe(data_oe),
	.rx_active(rx_active), .front_end_mode_out(front_end_mode_out));

// ---- bench/fskrx_host_model.sv ----
`timescale 1ns/1ps
module fskrx_host_model (
	input wire logic clk,
	input wire logic bit_clock,
	input wire logic data_bit,
	output logic [31:0] word,
	output logic [15:0] rises
);
	// ****
	// host sampling the data pin
	// ****
	logic last_reg = 1'h0;
	initial word = 32'h00000000;
	initial rises = 16'h0000;
	always @(posedge clk) begin
		last_reg <= bit_clock;
		if (bit_clock && !last_reg) begin
			word <= {word[30:0], data_bit};
			rises <= rises + 16'h0001;
		end
	end
endmodule

// ---- bench/fsk_rx_bit_sync_and_match_tb.sv ----
`timescale 1ns/1ps
module fsk_rx_bit_sync_and_match_tb;
	import fskrx_pkg::*;
	// ****
	// stimulus, observation and scenarios
	// ****
	logic clk, sys_rst, demod_raw_pin, irq_line_a, irq_line_b;
	logic synced_bit_out, data_oe, rx_active, front_end_mode_out;
	logic [7:0] rd_data;
	logic [1:0] mode_switch_pins, level_cmp_pins;
	logic [31:0] host_word;
	logic [15:0] host_rises;
	fskrx_bus_req_t bus_req;
	fskrx_fifo_evt_t fifo_evt;
	int fail_count = 0;
	int comparisons = 0;
	int a_hi = 0;
	int b_hi = 0;

	fskrx_top DUT (.clk(clk), .sys_rst(sys_rst), .bus_req(bus_req), .rd_data(rd_data),
		.demod_raw_pin(demod_raw_pin), .mode_switch_pins(mode_switch_pins),
		.level_cmp_pins(level_cmp_pins), .fifo_evt(fifo_evt), .irq_line_a(irq_line_a),
		.irq_line_b(irq_line_b), .synced_bit_out(synced_bit_out), .data_oe(data_oe),
		.rx_active(rx_active), .front_end_mode_out(front_end_mode_out));
	fskrx_host_model HOST (.clk(clk), .bit_clock(irq_line_b), .data_bit(synced_bit_out),
		.word(host_word), .rises(host_rises));

	initial begin
		clk = 1'h0;
		forever #50 clk = ~clk;
	end
	always @(posedge clk) begin
		if (irq_line_a) a_hi <= a_hi + 1;
		if (irq_line_b) b_hi <= b_hi + 1;
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			fail_count++;
			$display("CHECK FAILED %0t seen %h exp %h", $time, seen, exp);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		bus_req <= '{a, d, 1'h1, 1'h0};
		@(posedge clk);
		bus_req.we <= 1'h0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge clk);
		bus_req <= '{a, 8'h00, 1'h0, 1'h1};
		@(posedge clk);
		bus_req.re <= 1'h0;
		#1;
		chk({24'h000000, rd_data}, {24'h000000, e});
	endtask
	task automatic send(input logic [31:0] v, input int n, input int cpb);
		for (int i = n - 1; i >= 0; i--) begin
			demod_raw_pin <= v[i];
			cyc(cpb);
		end
	endtask

	task automatic t_regs;
		rd(8'h03, 8'h1F);
		rd(8'h07, 8'h00);
		rd(8'h06, 8'h00);
	endtask
	task automatic t_pins;
		wr(8'h00, 8'h04);
		wr(8'h02, 8'h01);
		mode_switch_pins <= 2'h1;
		cyc(5);
		chk(rx_active, 1'h1);
		chk(data_oe, 1'h1);
		chk(front_end_mode_out, 1'h1);
		mode_switch_pins <= 2'h2;
		cyc(5);
		chk(rx_active, 1'h0);
		wr(8'h00, 8'h01);
		cyc(2);
		chk(rx_active, 1'h1);
		wr(8'h02, 8'h00);
	endtask
	task automatic t_match;
		int a0;
		bit hit;
		wr(8'h08, 8'h3C);
		for (int k = 0; k < 4; k++) begin
			wr(8'h02, k == 1 ? 8'h24 : (k == 3 ? 8'h0C : 8'h04));
			wr(8'h05, k == 2 ? 8'h03 : 8'h02);
			a0 = a_hi;
			send(32'h00555555, 24, 131);
			send(k >= 2 ? 32'h000003CF : 32'h000003DF, 12, 131);
			chk(a_hi != a0, k == 1 || k == 2);
		end
		hit = 1'h0;
		for (int s = 0; s <= 8; s++) hit |= host_word[s +: 8] == 8'h3C;
		chk(hit, 1'h1);
	endtask
	task automatic t_bypass;
		int a0;
		int b0;
		wr(8'h02, 8'h06);
		cyc(2);
		a0 = a_hi;
		b0 = b_hi;
		send(32'h00555555, 24, 131);
		send(32'h000003C0, 12, 131);
		chk(b_hi != b0, 1'h0);
		chk(a_hi != a0, 1'h0);
		demod_raw_pin <= 1'h1;
		cyc(4);
		chk(synced_bit_out, 1'h1);
		wr(8'h02, 8'h00);
	endtask
	task automatic t_rate(input logic [7:0] md, input logic [7:0] oc, input int cpb);
		int r0;
		wr(8'h00, md);
		wr(8'h04, oc);
		send(32'h00555555, 24, cpb);
		r0 = host_rises;
		send(32'h55555555, 32, cpb);
		chk((host_rises - r0) inside {[30:34]}, 1'h1);
	endtask
	task automatic t_fifo;
		logic [2:0] e;
		wr(8'h00, 8'h09);
		for (int j = 0; j < 12; j++) begin
			e = 3'h4 >> (j / 4);
			fifo_evt <= e;
			wr(8'h05, {4'h0, 2'(j % 4), 2'(j % 4)});
			cyc(2);
			chk(irq_line_a, j % 4 == 1 ? e[2] : (j % 4 == 2 && e[1]));
			chk(irq_line_b, j % 4 == 1 && e[0]);
		end
		chk(data_oe, 1'h0);
		fifo_evt <= 3'h0;
	endtask
	task automatic t_level;
		wr(8'h00, 8'h01);
		wr(8'h02, 8'h80);
		wr(8'h05, 8'h51);
		for (int v = 0; v < 4; v++) begin
			level_cmp_pins <= 2'(v);
			cyc(2100);
			rd(8'h06, {6'h01, 2'(v)});
			chk(irq_line_a, v >= 2);
		end
		wr(8'h00, 8'h09);
		wr(8'h05, 8'h59);
		cyc(2);
		chk(irq_line_b, 1'h1);
		chk(irq_line_a, 1'h0);
		wr(8'h00, 8'h01);
		wr(8'h05, 8'h51);
		level_cmp_pins <= 2'h0;
		cyc(2100);
		rd(8'h05, 8'hD1);
		wr(8'h05, 8'hD1);
		cyc(2);
		chk(irq_line_a, 1'h0);
		rd(8'h05, 8'h51);
	endtask

	task automatic print_verdict;
		if (fail_count == 0 && comparisons > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	initial begin
		sys_rst = 1'h1;
		bus_req = '0;
		fifo_evt = '0;
		demod_raw_pin = 1'h0;
		mode_switch_pins = 2'h0;
		level_cmp_pins = 2'h0;
		repeat (8) @(posedge clk);
		sys_rst <= 1'h0;
		t_regs();
		t_pins();
		wr(8'h01, 8'h01);
		t_match();
		t_bypass();
		t_rate(8'h01, 8'h00, 131);
		t_rate(8'h11, 8'h00, 305);
		wr(8'h03, 8'h3F);
		t_rate(8'h01, 8'h01, 263);
		wr(8'h04, 8'h00);
		t_fifo();
		t_level();
		print_verdict();
	end
	initial begin
		cyc(95000);
		fail_count++;
		print_verdict();
	end
endmodule
